// File: src/sbad_consts.vh
// Constants for the system bus arbiter, address decoder and power-on configuration.
`ifndef SBAD_CONSTS_VH
`define SBAD_CONSTS_VH

`define SBAD_M_CPU          2'd0
`define SBAD_M_FLASH        2'd1
`define SBAD_M_AUDIO        2'd2
`define SBAD_MAX_BURST      5'd16
`define SBAD_RR_RESET       6'b00_01_10

`define SBAD_CTL_MODE_BIT   0
`define SBAD_CTL_BEN_BIT    4
`define SBAD_CTL_BACT_BIT   5

`define SBAD_CFG_REMAP_BIT  20
`define SBAD_CFG_DBG_BIT    4
`define SBAD_CFG_PKG_BIT    3
`define SBAD_CFG_WIDTH      21
`define SBAD_CFG_RESET      21'h00_0000
`define SBAD_CFG_STRAP_MSB  6

`define SBAD_BOOT_SRAM      3'b100
`define SBAD_BOOT_USB       3'b101
`define SBAD_BOOT_OTP       3'b110
`define SBAD_BOOT_SPI       3'b111

`define SBAD_SCLK_KHZ_00    17'h1_1940
`define SBAD_SCLK_KHZ_01    17'h0_8CA0
`define SBAD_SCLK_KHZ_10    17'h0_4650
`define SBAD_SCLK_KHZ_11    17'h0_0032

`define SBAD_ROM_LO_LAST    32'h0000_7FFF
`define SBAD_ROM_HI_BASE    32'h6000_0000
`define SBAD_ROM_HI_LAST    32'h6000_7FFF
`define SBAD_SRAM_LO_TOP    3'b000
`define SBAD_SRAM_HI_TOP    3'b001
`define SBAD_FLASH_TOP      4'h4
`define SBAD_GCR_BASE       32'hB100_0000
`define SBAD_GCR_MASK       32'h0000_01FF
`define SBAD_CLK_BASE       32'hB100_0200
`define SBAD_CLK_MASK       32'h0000_00FF
`define SBAD_WIN_MASK       32'h0000_0FFF
`define SBAD_SRAMCTL_BASE   32'hB100_4000
`define SBAD_SPIM_BASE      32'hB100_7000
`define SBAD_APU_BASE       32'hB100_8000
`define SBAD_USB_BASE       32'hB100_9000
`define SBAD_ADC_BASE       32'hB800_1000
`define SBAD_AIC_BASE       32'hB800_2000
`define SBAD_GPIO_BASE      32'hB800_3000
`define SBAD_I2C_BASE       32'hB800_4000
`define SBAD_PWM_BASE       32'hB800_7000
`define SBAD_RTC_BASE       32'hB800_8000
`define SBAD_SPIMS_BASE     32'hB800_A000
`define SBAD_TIMER_BASE     32'hB800_B000
`define SBAD_UART_BASE      32'hB800_C000
`define SBAD_NUM_SLV        18

`endif

// File: src/sbad_arbiter_decode.v
// System bus arbiter, memory-map decoder and power-on configuration capture.
//
// Function
// - Remap clear: low 32 KB to boot ROM, 0x2000_0000 region to SRAM.
// - Remap set: address zero region to SRAM, boot ROM at 0x6000_0000.
// - Region at 0x4000_0000 goes to the SPI flash controller.
// - High-speed register windows at 0xB100_xxxx decoded per block.
// - Peripheral 4 KB windows from 0xB800_1000 to 0xB800_C000 decoded.
// - Byte ordering is little-endian only.
// - Mode bit 0 selects fixed priority, 1 selects round robin.
// - Owner loses the bus after sixteen data transfers when another master is requesting.
// - Fixed priority: audio unit, then flash master, then processor core.
// - Boost enable plus external interrupt sets the boost active flag.
// - Boost active gives the processor core the highest priority.
// - Writing one to boost active clears it.
// - Software can never set boost active.
// - Round robin demotes the granted highest-priority master to lowest.
// - Round robin starts audio, flash, processor after reset.
// - Strap pins are sampled into the configuration register on every reset.
// - Flash speed straps: 72 MHz, 36 MHz, 18 MHz, 50 kHz.
// - Debug strap 0 enables debug and disables cipher; 1 is normal.
// - Package debug strap 0 gives five port B pins to debug.
// - Boot straps select test, SRAM, USB, OTP or SPI boot.
// - Remap is configuration bit 20.
// - Low seven configuration bits stay writable after capture.
// - Mode bit is control bit 0; mode and boost bits reset to zero.
`timescale 1ns/10ps
`include "sbad_consts.vh"

module sbad_arbiter_decode
(
  input  wire                       clk_sys,
  input  wire                       rst,
  input  wire [2:0]                 bus_req,
  input  wire                       xfer_done,
  input  wire                       addr_valid,
  input  wire [31:0]                haddr,
  input  wire [1:0]                 hsize,
  input  wire                       ctl_wr,
  input  wire [5:0]                 ctl_wr_data,
  input  wire                       cfg_wr,
  input  wire [20:0]                cfg_wr_data,
  input  wire [6:0]                 strap_pins,
  input  wire                       fast_irq_n,
  input  wire                       normal_irq_n,
  output reg  [2:0]                 bus_grant_r,
  output reg  [4:0]                 beat_cnt_r,
  output reg                        arb_mode_sel,
  output reg                        irq_boost_en,
  output reg                        irq_boost_active,
  output reg  [`SBAD_NUM_SLV-1:0]   slave_sel_r,
  output reg                        bus_error_r,
  output reg  [3:0]                 lane_en_r,
  output reg  [20:0]                power_on_cfg,
  output reg                        cfg_ready_r,
  output reg  [16:0]                flash_sclk_khz_r,
  output reg                        debug_mode_r,
  output reg                        dbg_port_pins_r,
  output reg                        boot_test_r,
  output reg                        boot_sram_r,
  output reg                        boot_usb_r,
  output reg                        boot_otp_r,
  output reg                        boot_spi_r
);

  localparam [2:0] ST_FILL = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  reg  [2:0]                 cfg_state_r;
  reg  [2:0]                 cfg_state_nxt;
  reg  [1:0]                 fill_cnt_r;
  reg  [6:0]                 strap_s1_r;
  reg  [6:0]                 strap_s2_r;
  reg  [6:0]                 strap_s3_r;
  reg  [1:0]                 irq_s1_r;
  reg  [1:0]                 irq_s2_r;
  reg  [1:0]                 irq_s3_r;
  reg                        irq_seen_r;
  reg  [5:0]                 rr_order_r;
  reg  [5:0]                 rr_order_nxt;
  reg  [2:0]                 grant_nxt;
  reg  [2:0]                 cand;
  reg  [1:0]                 rr_win;
  reg  [`SBAD_NUM_SLV-1:0]   sel_nxt;
  reg  [3:0]                 lane_nxt;
  reg  [6:0]                 cfg_low;
  wire                       rearb;
  wire                       owner_req;
  wire                       last_beat;
  wire                       irq_hit;
  wire                       remap;

  assign owner_req = |(bus_req & bus_grant_r);
  assign last_beat = xfer_done && (beat_cnt_r == `SBAD_MAX_BURST - 5'd1);
  assign rearb     = !owner_req || last_beat;
  assign remap     = power_on_cfg[`SBAD_CFG_REMAP_BIT];

  // Interrupt pins count as asserted once the second and third stages agree low.
  assign irq_hit = (!irq_s2_r[0] && !irq_s3_r[0]) || (!irq_s2_r[1] && !irq_s3_r[1]);

  // Candidate set skips the owner after a burst break when anyone else waits.
  always @*
  begin
    cand = bus_req;
    if (last_beat && |(bus_req & ~bus_grant_r))
    begin
      cand = bus_req & ~bus_grant_r;
    end
  end

  // Winner selection and round-robin order update.
  always @*
  begin
    grant_nxt    = bus_grant_r;
    rr_order_nxt = rr_order_r;
    rr_win       = `SBAD_M_CPU;
    if (rearb)
    begin
      if (cand == 3'b000)
      begin
        grant_nxt = 3'b001;
      end
      else if (irq_boost_active && cand[`SBAD_M_CPU])
      begin
        grant_nxt = 3'b001;
      end
      else if (!arb_mode_sel)
      begin
        if (cand[`SBAD_M_AUDIO])
        begin
          grant_nxt = 3'b100;
        end
        else if (cand[`SBAD_M_FLASH])
        begin
          grant_nxt = 3'b010;
        end
        else
        begin
          grant_nxt = 3'b001;
        end
      end
      else
      begin
        if (cand[rr_order_r[1:0]])
        begin
          rr_win       = rr_order_r[1:0];
          rr_order_nxt = {rr_order_r[1:0], rr_order_r[5:2]};
        end
        else if (cand[rr_order_r[3:2]])
        begin
          rr_win       = rr_order_r[3:2];
          rr_order_nxt = {rr_order_r[3:2], rr_order_r[5:4], rr_order_r[1:0]};
        end
        else
        begin
          rr_win = rr_order_r[5:4];
        end
        grant_nxt = 3'b001 << rr_win;
      end
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_grant_r <= 3'b001;
      beat_cnt_r  <= 5'd0;
      rr_order_r  <= `SBAD_RR_RESET;
    end
    else
    begin
      bus_grant_r <= grant_nxt;
      rr_order_r  <= rr_order_nxt;
      if (rearb)
      begin
        beat_cnt_r <= 5'd0;
      end
      else if (xfer_done)
      begin
        beat_cnt_r <= beat_cnt_r + 5'd1;
      end
    end
  end

  // Bus control bits and the interrupt priority boost.
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      arb_mode_sel     <= 1'b0;
      irq_boost_en     <= 1'b0;
      irq_boost_active <= 1'b0;
      irq_s1_r         <= 2'b11;
      irq_s2_r         <= 2'b11;
      irq_s3_r         <= 2'b11;
      irq_seen_r       <= 1'b0;
    end
    else
    begin
      irq_s1_r   <= {normal_irq_n, fast_irq_n};
      irq_s2_r   <= irq_s1_r;
      irq_s3_r   <= irq_s2_r;
      irq_seen_r <= irq_hit;
      if (ctl_wr)
      begin
        arb_mode_sel <= ctl_wr_data[`SBAD_CTL_MODE_BIT];
        irq_boost_en <= ctl_wr_data[`SBAD_CTL_BEN_BIT];
      end
      // A new interrupt edge beats a clearing write in the same cycle.
      if (irq_boost_en && irq_hit && !irq_seen_r)
      begin
        irq_boost_active <= 1'b1;
      end
      else if (ctl_wr && ctl_wr_data[`SBAD_CTL_BACT_BIT])
      begin
        irq_boost_active <= 1'b0;
      end
    end
  end

  // Address decode; a window matches when the bits above its size equal its base.
  always @*
  begin
    sel_nxt     = {`SBAD_NUM_SLV{1'b0}};
    sel_nxt[0]  = remap ? (haddr >= `SBAD_ROM_HI_BASE && haddr <= `SBAD_ROM_HI_LAST)
                        : (haddr <= `SBAD_ROM_LO_LAST);
    sel_nxt[1]  = remap ? (haddr[31:29] == `SBAD_SRAM_LO_TOP)
                        : (haddr[31:29] == `SBAD_SRAM_HI_TOP);
    sel_nxt[2]  = (haddr[31:28] == `SBAD_FLASH_TOP);
    sel_nxt[3]  = ((haddr & ~`SBAD_GCR_MASK) == `SBAD_GCR_BASE);
    sel_nxt[4]  = ((haddr & ~`SBAD_CLK_MASK) == `SBAD_CLK_BASE);
    sel_nxt[5]  = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_SRAMCTL_BASE);
    sel_nxt[6]  = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_SPIM_BASE);
    sel_nxt[7]  = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_APU_BASE);
    sel_nxt[8]  = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_USB_BASE);
    sel_nxt[9]  = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_ADC_BASE);
    sel_nxt[10] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_AIC_BASE);
    sel_nxt[11] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_GPIO_BASE);
    sel_nxt[12] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_I2C_BASE);
    sel_nxt[13] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_PWM_BASE);
    sel_nxt[14] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_RTC_BASE);
    sel_nxt[15] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_SPIMS_BASE);
    sel_nxt[16] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_TIMER_BASE);
    sel_nxt[17] = ((haddr & ~`SBAD_WIN_MASK) == `SBAD_UART_BASE);
  end

  // Little-endian byte lanes: the lowest address byte rides on lane 0.
  always @*
  begin
    case (hsize)
      2'b00:   lane_nxt = 4'b0001 << haddr[1:0];
      2'b01:   lane_nxt = haddr[1] ? 4'b1100 : 4'b0011;
      default: lane_nxt = 4'b1111;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      slave_sel_r <= {`SBAD_NUM_SLV{1'b0}};
      bus_error_r <= 1'b0;
      lane_en_r   <= 4'b0000;
    end
    else
    begin
      slave_sel_r <= addr_valid ? sel_nxt : {`SBAD_NUM_SLV{1'b0}};
      bus_error_r <= addr_valid && (sel_nxt == {`SBAD_NUM_SLV{1'b0}});
      lane_en_r   <= addr_valid ? lane_nxt : 4'b0000;
    end
  end

  // Strap capture: fill the synchronisers after reset, then load once the last two stages agree.
  always @*
  begin
    case (cfg_state_r)
      ST_FILL: cfg_state_nxt = (fill_cnt_r == 2'd3 && strap_s2_r == strap_s3_r) ? ST_LOAD : ST_FILL;
      ST_LOAD: cfg_state_nxt = ST_RUN;
      ST_RUN:  cfg_state_nxt = ST_RUN;
      default: cfg_state_nxt = ST_FILL;
    endcase
  end

  always @*
  begin
    cfg_low = power_on_cfg[`SBAD_CFG_STRAP_MSB:0];
    if (cfg_state_r == ST_LOAD)
    begin
      cfg_low = strap_s3_r;
    end
    else if (cfg_state_r == ST_RUN && cfg_wr)
    begin
      cfg_low = cfg_wr_data[`SBAD_CFG_STRAP_MSB:0];
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_state_r  <= ST_FILL;
      fill_cnt_r   <= 2'd0;
      strap_s1_r   <= 7'h00;
      strap_s2_r   <= 7'h00;
      strap_s3_r   <= 7'h00;
      power_on_cfg <= `SBAD_CFG_RESET;
      cfg_ready_r  <= 1'b0;
    end
    else
    begin
      cfg_state_r <= cfg_state_nxt;
      strap_s1_r  <= strap_pins;
      strap_s2_r  <= strap_s1_r;
      strap_s3_r  <= strap_s2_r;
      cfg_ready_r <= (cfg_state_nxt == ST_RUN);
      if (cfg_state_r == ST_FILL)
      begin
        fill_cnt_r <= fill_cnt_r + 2'd1;
      end
      power_on_cfg[`SBAD_CFG_STRAP_MSB:0] <= cfg_low;
      if (cfg_state_r == ST_RUN && cfg_wr)
      begin
        power_on_cfg[`SBAD_CFG_REMAP_BIT] <= cfg_wr_data[`SBAD_CFG_REMAP_BIT];
      end
    end
  end

  // Decoded strap functions, registered from the next configuration value.
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      flash_sclk_khz_r <= `SBAD_SCLK_KHZ_00;
      debug_mode_r     <= 1'b0;
      dbg_port_pins_r  <= 1'b0;
      boot_test_r      <= 1'b0;
      boot_sram_r      <= 1'b0;
      boot_usb_r       <= 1'b0;
      boot_otp_r       <= 1'b0;
      boot_spi_r       <= 1'b0;
    end
    else
    begin
      case (cfg_low[6:5])
        2'b00:   flash_sclk_khz_r <= `SBAD_SCLK_KHZ_00;
        2'b01:   flash_sclk_khz_r <= `SBAD_SCLK_KHZ_01;
        2'b10:   flash_sclk_khz_r <= `SBAD_SCLK_KHZ_10;
        default: flash_sclk_khz_r <= `SBAD_SCLK_KHZ_11;
      endcase
      debug_mode_r    <= !cfg_low[`SBAD_CFG_DBG_BIT];
      dbg_port_pins_r <= !cfg_low[`SBAD_CFG_PKG_BIT];
      boot_test_r     <= !cfg_low[2];
      boot_sram_r     <= (cfg_low[2:0] == `SBAD_BOOT_SRAM);
      boot_usb_r      <= (cfg_low[2:0] == `SBAD_BOOT_USB);
      boot_otp_r      <= (cfg_low[2:0] == `SBAD_BOOT_OTP);
      boot_spi_r      <= (cfg_low[2:0] == `SBAD_BOOT_SPI);
    end
  end

endmodule

// File: sim/sbad_props.sv
// Checker for the arbiter, decoder and configuration ports.
`timescale 1ns/10ps
`include "sbad_consts.vh"
module sbad_props
(
  input wire                     clk_sys,
  input wire                     rst,
  input wire [2:0]               bus_req,
  input wire                     xfer_done,
  input wire                     addr_valid,
  input wire [31:0]              haddr,
  input wire [1:0]               hsize,
  input wire                     fast_irq_n,
  input wire                     normal_irq_n,
  input wire [6:0]               strap_pins,
  input wire [2:0]               bus_grant_r,
  input wire [4:0]               beat_cnt_r,
  input wire                     arb_mode_sel,
  input wire                     irq_boost_en,
  input wire                     irq_boost_active,
  input wire [`SBAD_NUM_SLV-1:0] slave_sel_r,
  input wire                     bus_error_r,
  input wire [3:0]               lane_en_r,
  input wire [20:0]              power_on_cfg,
  input wire                     cfg_ready_r
);
  reg  [2:0] quiet_r;
  wire       owner_req = |(bus_req & bus_grant_r);

  // Cycles since an interrupt line was last low, saturating.
  always @(posedge clk_sys)
  begin
    if (rst || !fast_irq_n || !normal_irq_n)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  grant_onehot_a: assert property ($onehot(bus_grant_r))
    else $error("grant not one-hot");
  park_core_a: assert property (bus_req == 3'h0 |=> bus_grant_r == 3'h1)
    else $error("idle bus not parked on core");
  fixed_prio_a: assert property (
    !arb_mode_sel && !irq_boost_active && bus_req[2] && !owner_req |=> bus_grant_r == 3'h4)
    else $error("audio unit not first");
  boost_core_a: assert property (
    irq_boost_active && bus_req[0] && !owner_req |=> bus_grant_r == 3'h1)
    else $error("boosted core not granted");
  burst_break_a: assert property (
    xfer_done && beat_cnt_r == 5'hf && |(bus_req & ~bus_grant_r)
    |=> (bus_grant_r & $past(bus_grant_r)) == 3'h0)
    else $error("burst not broken");
  beat_count_a: assert property (
    xfer_done && owner_req && beat_cnt_r < 5'hf |=> beat_cnt_r == $past(beat_cnt_r) + 5'h1)
    else $error("beat count wrong");
  rom_remap_a: assert property (
    addr_valid && haddr[31:15] == 17'h0
    |=> slave_sel_r[1:0] == ($past(power_on_cfg[20]) ? 2'h2 : 2'h1))
    else $error("low region routed wrongly");
  error_excl_a: assert property (addr_valid |=> bus_error_r == (slave_sel_r == '0))
    else $error("error and select disagree");
  byte_lane_a: assert property (
    addr_valid && hsize == 2'h0 |=> lane_en_r == 4'h1 << $past(haddr[1:0]))
    else $error("byte lane wrong");
  cfg_capture_a: assert property ($rose(cfg_ready_r) |-> power_on_cfg[6:0] == strap_pins)
    else $error("straps not captured");
  boost_set_a: assert property (
    $rose(irq_boost_active) |-> irq_boost_en && quiet_r < 3'h6)
    else $error("boost flag set without interrupt");
  ctl_reset_a: assert property (
    $fell(rst) |-> !arb_mode_sel && !irq_boost_en && !irq_boost_active)
    else $error("control bits not cleared");

  cover property (xfer_done && beat_cnt_r == 5'hf);
  cover property ($rose(irq_boost_active));
  cover property (arb_mode_sel && $changed(bus_grant_r));
  cover property (bus_error_r);
endmodule

bind sbad_arbiter_decode sbad_props sbad_props_i
(
  .clk_sys, .rst, .bus_req, .xfer_done, .addr_valid, .haddr, .hsize, .fast_irq_n,
  .normal_irq_n, .strap_pins, .bus_grant_r, .beat_cnt_r, .arb_mode_sel, .irq_boost_en,
  .irq_boost_active, .slave_sel_r, .bus_error_r, .lane_en_r, .power_on_cfg, .cfg_ready_r
);

// File: sim/sbad_masters.sv
// Model of the three on-chip bus masters.
`timescale 1ns/10ps
module sbad_masters
(
  input  wire       clk_sys,
  input  wire [2:0] want,
  input  wire       stall,
  input  wire [2:0] bus_grant_r,
  output reg  [2:0] bus_req = 3'h0,
  output wire       xfer_done
);
  always @(posedge clk_sys)
  begin
    bus_req <= want;
  end
  // A granted master that still requests moves one beat per cycle unless stalled.
  assign xfer_done = |(bus_grant_r & bus_req) & ~stall;
endmodule

// File: sim/testbench.sv
// Self-checking bench for the arbiter, decoder and power-on configuration.
`timescale 1ns/10ps
`include "sbad_consts.vh"
module testbench;
  logic        clk_sys;
  logic        rst = 1'b1, addr_valid = 1'b0, ctl_wr = 1'b0, cfg_wr = 1'b0, stall = 1'b1;
  logic        fast_irq_n = 1'b1, normal_irq_n = 1'b1;
  logic [1:0]  hsize = 2'h2;
  logic [2:0]  want = 3'h0;
  logic [5:0]  ctl_wr_data = 6'h00;
  logic [6:0]  strap_pins = 7'h7f;
  logic [20:0] cfg_wr_data = 21'h00_0000;
  logic [31:0] haddr = 32'h0000_0000, d;
  integer      seed = 32'h0000_f174, n_fail = 0, num_checks = 0, i, j, k, m, n_x;
  wire  [2:0]  bus_req, bus_grant_r;
  wire         xfer_done, arb_mode_sel, irq_boost_en, irq_boost_active, bus_error_r;
  wire         cfg_ready_r, debug_mode_r, dbg_port_pins_r, boot_test_r, boot_sram_r;
  wire         boot_usb_r, boot_otp_r, boot_spi_r;
  wire  [3:0]  lane_en_r;
  wire  [4:0]  beat_cnt_r;
  wire  [16:0] flash_sclk_khz_r;
  wire  [17:0] slave_sel_r;
  wire  [20:0] power_on_cfg;
  wire  [30:0] cfg_view = {power_on_cfg[6:0], flash_sclk_khz_r, debug_mode_r,
                           dbg_port_pins_r, boot_test_r, boot_sram_r, boot_usb_r,
                           boot_otp_r, boot_spi_r};
  logic [31:0] ta [0:24] = '{32'h0000_7ffc, 32'h2000_0000, 32'h4000_0000, 32'hb100_01fc,
    32'hb100_0200, 32'hb100_4000, 32'hb100_7000, 32'hb100_8ffc, 32'hb100_9000,
    32'hb800_1000, 32'hb800_2000, 32'hb800_3000, 32'hb800_4000, 32'hb800_7000,
    32'hb800_8000, 32'hb800_a000, 32'hb800_b000, 32'hb800_cffc, 32'hb100_0300,
    32'hb800_5000, 32'h0000_8000, 32'h0000_0000, 32'h1fff_fffc, 32'h6000_7ffc,
    32'h6000_8000};
  logic [4:0]  ti [0:24] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h4, 5'h5, 5'h6, 5'h7, 5'h8, 5'h9,
    5'ha, 5'hb, 5'hc, 5'hd, 5'he, 5'hf, 5'h10, 5'h11, 5'h12, 5'h12, 5'h12, 5'h1, 5'h1,
    5'h0, 5'h12};
  logic [2:0]  aw [0:3] = '{3'h6, 3'h3, 3'h5, 3'h6};
  logic [2:0]  ag [0:7] = '{3'h4, 3'h2, 3'h4, 3'h4, 3'h4, 3'h2, 3'h1, 3'h4};

  sbad_arbiter_decode sbad_arbiter_decode_i
  (
    .clk_sys, .rst, .bus_req, .xfer_done, .addr_valid, .haddr, .hsize, .ctl_wr,
    .ctl_wr_data, .cfg_wr, .cfg_wr_data, .strap_pins, .fast_irq_n, .normal_irq_n,
    .bus_grant_r, .beat_cnt_r, .arb_mode_sel, .irq_boost_en, .irq_boost_active,
    .slave_sel_r, .bus_error_r, .lane_en_r, .power_on_cfg, .cfg_ready_r,
    .flash_sclk_khz_r, .debug_mode_r, .dbg_port_pins_r, .boot_test_r, .boot_sram_r,
    .boot_usb_r, .boot_otp_r, .boot_spi_r
  );
  sbad_masters sbad_masters_i (.clk_sys, .want, .stall, .bus_grant_r, .bus_req, .xfer_done);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [30:0] exp_cfg(input logic [6:0] p);
    logic [16:0] khz;
    begin
      khz = p[6] ? (p[5] ? `SBAD_SCLK_KHZ_11 : `SBAD_SCLK_KHZ_10)
                 : (p[5] ? `SBAD_SCLK_KHZ_01 : `SBAD_SCLK_KHZ_00);
      exp_cfg = {p, khz, ~p[4], ~p[3], p[2] ? 5'h08 >> p[1:0] : 5'h10};
    end
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task summarize;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  task tick(input integer n);
  begin
    repeat (n) @(posedge clk_sys);
  end
  endtask

  task do_reset(input logic [6:0] p);
  begin
    @(posedge clk_sys);
    strap_pins <= p;
    want <= 3'h0;
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    m = 0;
    while (cfg_ready_r !== 1'b1 && m < 20)
    begin
      @(posedge clk_sys);
      #1;
      m = m + 1;
    end
  end
  endtask

  // Register writes take one edge; a further edge lets derived outputs settle.
  task ctl_write(input logic [5:0] v);
  begin
    @(posedge clk_sys);
    ctl_wr <= 1'b1;
    ctl_wr_data <= v;
    tick(1);
    ctl_wr <= 1'b0;
    tick(1);
    #1;
  end
  endtask

  task access(input logic [31:0] a, input logic [1:0] s);
  begin
    @(posedge clk_sys);
    addr_valid <= 1'b1;
    haddr <= a;
    hsize <= s;
    tick(1);
    #1;
  end
  endtask

  initial
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      d = $random(seed);
      d[2:0] = i[2:0];
      d[6:5] = i[1:0];
      do_reset(d[6:0]);
      chk(cfg_view, exp_cfg(d[6:0]));
    end
    chk({arb_mode_sel, irq_boost_en, irq_boost_active}, 3'h0);
    for (i = 0; i < 29; i = i + 1)
    begin
      if (i == 21)
      begin
        d = 21'h10_0000 | ($random(seed) & 32'h0000_007f);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_wr_data <= d[20:0];
        tick(1);
        cfg_wr <= 1'b0;
        tick(1);
        #1;
        chk(power_on_cfg, d);
        chk(cfg_view, exp_cfg(d[6:0]));
      end
      if (i < 25)
        access(ta[i], 2'h2);
      else
        access(32'hb800_c000 | ($random(seed) & 32'h0000_0ffc), 2'h2);
      chk({bus_error_r, slave_sel_r}, 19'h1 << (i < 25 ? ti[i] : 5'h11));
    end
    for (i = 0; i < 16; i = i + 1)
    begin
      access(32'h0000_0100 | i[1:0], i[3:2]);
      chk(lane_en_r, i[3:2] == 2'h0 ? 4'h1 << i[1:0] : i[3:2] == 2'h1 ? (i[1] ? 4'hc : 4'h3) : 4'hf);
    end
    @(posedge clk_sys);
    addr_valid <= 1'b0;
    for (k = 0; k < 2; k = k + 1)
    begin
      do_reset(7'h7f);
      ctl_write({5'h00, k[0]});
      for (i = 0; i < 4; i = i + 1)
      begin
        @(posedge clk_sys);
        want <= aw[i];
        tick(3);
        #1;
        chk(bus_grant_r, ag[4 * k + i]);
      end
    end
    do_reset(7'h7f);
    @(posedge clk_sys);
    want <= 3'h6;
    tick(3);
    #1;
    n_x = 0;
    j = 0;
    while (bus_grant_r === 3'h4 && j < 200)
    begin
      @(posedge clk_sys);
      if (xfer_done === 1'b1)
        n_x = n_x + 1;
      stall <= $random(seed);
      j = j + 1;
      #1;
    end
    chk(n_x, 32'h0000_0010);
    chk(bus_grant_r, 3'h2);
    @(posedge clk_sys);
    stall <= 1'b1;
    for (j = 0; j < 3; j = j + 1)
    begin
      ctl_write({1'b1, j != 0, 4'h0});
      @(posedge clk_sys);
      fast_irq_n <= j != 2;
      normal_irq_n <= j == 2;
      tick(2);
      fast_irq_n <= 1'b1;
      normal_irq_n <= 1'b1;
      tick(6);
      #1;
      chk(irq_boost_active, j != 0);
    end
    @(posedge clk_sys);
    want <= 3'h5;
    tick(3);
    #1;
    chk(bus_grant_r, 3'h1);
    ctl_write(6'h30);
    chk(irq_boost_active, 1'b0);
    @(posedge clk_sys);
    want <= 3'h6;
    tick(3);
    #1;
    chk(bus_grant_r, 3'h4);
    @(posedge clk_sys);
    want <= 3'h0;
    tick(3);
    #1;
    chk(bus_grant_r, 3'h1);
    summarize;
  end

  initial
  begin
    #50000;
    n_fail = n_fail + 1;
    summarize;
  end
endmodule
